// ---- verilog/fpeg_guard.sv ----
// flash program/erase guard: key unlock, lockout, external-move steering, timed ops
// assumes the core and flash macro share pclk; flash_rdata follows flash_addr combinationally
//
// Notes on behaviour
// - one flash op allowed only after key codes 0xa5 then 0xf1.
// - no time limit between the two key writes.
// - wrong code or order locks out flash ops until reset.
// - flash attempt before unlock completes also locks out.
// - lock re-arms as every op starts; codes needed again each time.
// - write enable set steers external-move writes to flash.
// - write enable stays set until software clears it.
// - byte program only clears bits; only erase sets them.
// - erase clears a whole 512-byte page to 0xff.
// - with erase enable, external-move write erases its page, data ignored.
// - with erase enable clear, external-move write programs the byte.
// - ops are timed internally; no polling needed.
// - core is stalled for the whole op.
// - top 512 bytes are reserved, never written or erased.
// - write enable clear sends external-move writes to on-chip ram.
// - reserved region access raises a flash-error reset.
`timescale 1ns/100ps
`default_nettype none
module fpeg_guard #(
  parameter int ERASE_CYC = fpeg_pkg::ERASE_CYCLES,
  parameter int WRITE_CYC = fpeg_pkg::WRITE_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // external-move write from the core
  input  wire logic        xm_wr,
  input  wire logic [15:0] xm_addr,
  input  wire logic [7:0]  xm_data,
  output var  logic        cpu_stall,
  output var  logic        flash_err_rst,
  // on-chip external data ram
  output var  logic        onchip_external_data_ram_we,
  output var  logic [15:0] onchip_external_data_ram_addr,
  output var  logic [7:0]  onchip_external_data_ram_wdata,
  // flash macro
  input  wire logic [7:0]  flash_rdata,
  output var  logic [12:0] flash_addr,
  output var  logic [7:0]  flash_wdata,
  output var  logic        flash_prog,
  output var  logic        flash_erase
);
  if (ERASE_CYC < 1 || WRITE_CYC < 1) begin : g_bad_timing
    $error("fpeg_guard: op cycle counts must be at least one");
  end

  function automatic logic is_reserved(input logic [15:0] a);
    is_reserved = (a[fpeg_pkg::FLASH_AW-1:0] >= fpeg_pkg::RESERVED_BASE);
  endfunction : is_reserved

  function automatic logic [12:0] page_base(input logic [15:0] a);
    page_base = {a[fpeg_pkg::FLASH_AW-1:fpeg_pkg::PAGE_AW], 9'h000};
  endfunction : page_base

  // apb
  logic [31:0]         prdata_r,  prdata_nxt;
  logic                pready_r,  pready_nxt;
  logic                pslverr_r, pslverr_nxt;
  // control and unlock
  logic [1:0]          ctrl_r,    ctrl_nxt;
  fpeg_pkg::fpeg_key_t key_r,     key_nxt;
  // operation
  fpeg_pkg::fpeg_op_t  op_r,      op_nxt;
  logic [31:0]         cnt_r,     cnt_nxt;
  logic [7:0]          data_r,    data_nxt;
  logic [7:0]          old_r,     old_nxt;
  logic [12:0]         faddr_r,   faddr_nxt;
  logic [7:0]          fwdata_r,  fwdata_nxt;
  logic                fprog_r,   fprog_nxt;
  logic                ferase_r,  ferase_nxt;
  logic                stall_r,   stall_nxt;
  logic                err_r,     err_nxt;
  // ram path
  logic                xwe_r,     xwe_nxt;
  logic [15:0]         xaddr_r,   xaddr_nxt;
  logic [7:0]          xdata_r,   xdata_nxt;

  logic setup, wr_go, mapped, ctrl_wr, key_wr, to_flash, fl_try, fl_start;

  assign setup    = psel & ~penable;
  assign wr_go    = psel & penable & pwrite & pready_r & ~pslverr_r;
  assign ctrl_wr  = wr_go && (paddr == fpeg_pkg::CTRL_OFF);
  assign key_wr   = wr_go && (paddr == fpeg_pkg::KEY_OFF);
  assign mapped   = (paddr == fpeg_pkg::CTRL_OFF) || (paddr == fpeg_pkg::KEY_OFF) ||
                    (paddr == fpeg_pkg::STAT_OFF);
  assign to_flash = xm_wr & ctrl_r[fpeg_pkg::CTRL_WE_BIT] & (op_r == fpeg_pkg::OP_IDLE);
  assign fl_try   = to_flash & ~is_reserved(xm_addr);
  assign fl_start = fl_try & (key_r == fpeg_pkg::KS_OPEN);

  // apb slave, zero wait states
  always_comb
  begin
    pready_nxt  = setup;
    pslverr_nxt = setup & ~mapped;
    prdata_nxt  = prdata_r;
    if (setup)
    begin
      prdata_nxt = 32'h0000_0000;
      if (paddr == fpeg_pkg::CTRL_OFF)
        prdata_nxt[1:0] = ctrl_r;
      else if (paddr == fpeg_pkg::STAT_OFF)
      begin
        prdata_nxt[fpeg_pkg::STAT_BUSY_BIT]  = (op_r != fpeg_pkg::OP_IDLE);
        prdata_nxt[fpeg_pkg::STAT_LOCK_BIT]  = (key_r == fpeg_pkg::KS_LOCKOUT);
        prdata_nxt[fpeg_pkg::STAT_OPEN_BIT]  = (key_r == fpeg_pkg::KS_OPEN);
        prdata_nxt[fpeg_pkg::STAT_FIRST_BIT] = (key_r == fpeg_pkg::KS_FIRST);
      end
    end
  end

  // control bits and unlock sequence
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    key_nxt  = key_r;
    if (ctrl_wr)
      ctrl_nxt = pwdata[1:0];
    if (key_wr)
    begin
      unique case (key_r)
        fpeg_pkg::KS_LOCKED:
          key_nxt = (pwdata[7:0] == fpeg_pkg::KEY_FIRST) ? fpeg_pkg::KS_FIRST
                                                         : fpeg_pkg::KS_LOCKOUT;
        fpeg_pkg::KS_FIRST:
          key_nxt = (pwdata[7:0] == fpeg_pkg::KEY_SECOND) ? fpeg_pkg::KS_OPEN
                                                          : fpeg_pkg::KS_LOCKOUT;
        fpeg_pkg::KS_OPEN:
          key_nxt = fpeg_pkg::KS_LOCKOUT;
        fpeg_pkg::KS_LOCKOUT:
          key_nxt = fpeg_pkg::KS_LOCKOUT;
      endcase
    end
    if (fl_try)
    begin
      if (fl_start)
        key_nxt = fpeg_pkg::KS_LOCKED;
      else
        key_nxt = fpeg_pkg::KS_LOCKOUT;
    end
  end

  // steering, timed operations, stall and error reset
  always_comb
  begin
    op_nxt     = op_r;
    cnt_nxt    = cnt_r;
    data_nxt   = data_r;
    old_nxt    = old_r;
    faddr_nxt  = faddr_r;
    fwdata_nxt = fwdata_r;
    fprog_nxt  = fprog_r;
    ferase_nxt = ferase_r;
    xwe_nxt    = 1'b0;
    xaddr_nxt  = xaddr_r;
    xdata_nxt  = xdata_r;
    err_nxt    = to_flash & is_reserved(xm_addr);
    if (xm_wr && !ctrl_r[fpeg_pkg::CTRL_WE_BIT] && op_r == fpeg_pkg::OP_IDLE)
    begin
      xwe_nxt   = 1'b1;
      xaddr_nxt = xm_addr;
      xdata_nxt = xm_data;
    end
    unique case (op_r)
      fpeg_pkg::OP_IDLE:
        if (fl_start)
        begin
          if (ctrl_r[fpeg_pkg::CTRL_EE_BIT])
          begin
            op_nxt     = fpeg_pkg::OP_ERASE;
            faddr_nxt  = page_base(xm_addr);
            fwdata_nxt = fpeg_pkg::ERASED_BYTE;
            ferase_nxt = 1'b1;
            cnt_nxt    = ERASE_CYC - 1;
          end
          else
          begin
            op_nxt    = fpeg_pkg::OP_READ;
            faddr_nxt = xm_addr[fpeg_pkg::FLASH_AW-1:0];
            data_nxt  = xm_data;
          end
        end
      fpeg_pkg::OP_READ:
      begin
        old_nxt    = flash_rdata;
        fwdata_nxt = flash_rdata & data_r;
        fprog_nxt  = 1'b1;
        cnt_nxt    = WRITE_CYC - 1;
        op_nxt     = fpeg_pkg::OP_PROG;
      end
      fpeg_pkg::OP_PROG, fpeg_pkg::OP_ERASE:
        if (cnt_r == 32'h0000_0000)
        begin
          op_nxt     = fpeg_pkg::OP_IDLE;
          fprog_nxt  = 1'b0;
          ferase_nxt = 1'b0;
        end
        else
          cnt_nxt = cnt_r - 32'h0000_0001;
    endcase
    stall_nxt = (op_nxt != fpeg_pkg::OP_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_r    <= fpeg_pkg::CTRL_RESET;
      key_r     <= fpeg_pkg::KS_LOCKED;
      op_r      <= fpeg_pkg::OP_IDLE;
      cnt_r     <= 32'h0000_0000;
      data_r    <= 8'h00;
      old_r     <= 8'h00;
      faddr_r   <= 13'h0000;
      fwdata_r  <= 8'h00;
      fprog_r   <= 1'b0;
      ferase_r  <= 1'b0;
      stall_r   <= 1'b0;
      err_r     <= 1'b0;
      xwe_r     <= 1'b0;
      xaddr_r   <= 16'h0000;
      xdata_r   <= 8'h00;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ctrl_r    <= ctrl_nxt;
      key_r     <= key_nxt;
      op_r      <= op_nxt;
      cnt_r     <= cnt_nxt;
      data_r    <= data_nxt;
      old_r     <= old_nxt;
      faddr_r   <= faddr_nxt;
      fwdata_r  <= fwdata_nxt;
      fprog_r   <= fprog_nxt;
      ferase_r  <= ferase_nxt;
      stall_r   <= stall_nxt;
      err_r     <= err_nxt;
      xwe_r     <= xwe_nxt;
      xaddr_r   <= xaddr_nxt;
      xdata_r   <= xdata_nxt;
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign cpu_stall     = stall_r;
  assign flash_err_rst = err_r;
  assign onchip_external_data_ram_we       = xwe_r;
  assign onchip_external_data_ram_addr     = xaddr_r;
  assign onchip_external_data_ram_wdata    = xdata_r;
  assign flash_addr    = faddr_r;
  assign flash_wdata   = fwdata_r;
  assign flash_prog    = fprog_r;
  assign flash_erase   = ferase_r;

  // helper: length of each pulse on the flash strobes
  logic [31:0] plen_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      plen_r <= 32'h0000_0000;
    else if (fprog_r || ferase_r)
      plen_r <= plen_r + 32'h0000_0001;
    else
      plen_r <= 32'h0000_0000;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_key_order: assert property (
    $rose(key_r == fpeg_pkg::KS_OPEN) |-> $past(key_r) == fpeg_pkg::KS_FIRST &&
      $past(key_wr) && $past(pwdata[7:0]) == fpeg_pkg::KEY_SECOND)
    else $error("unlock opened without the second code after the first");
  a_no_timeout: assert property (
    (key_r == fpeg_pkg::KS_FIRST && !key_wr && !to_flash) |=> key_r == fpeg_pkg::KS_FIRST)
    else $error("half-done unlock decayed on its own");
  a_lockout_sticky: assert property (
    key_r == fpeg_pkg::KS_LOCKOUT |=> key_r == fpeg_pkg::KS_LOCKOUT && !fprog_r && !ferase_r)
    else $error("lockout left or flash op started during lockout");
  a_early_attempt: assert property (
    (fl_try && key_r != fpeg_pkg::KS_OPEN) |=> key_r == fpeg_pkg::KS_LOCKOUT &&
      op_r == fpeg_pkg::OP_IDLE)
    else $error("flash attempt before unlock did not lock out");
  a_lock_rearm: assert property (
    fl_start |=> key_r == fpeg_pkg::KS_LOCKED && op_r != fpeg_pkg::OP_IDLE)
    else $error("lock not re-armed at op start");
  a_flash_route: assert property (
    (xm_wr && ctrl_r[fpeg_pkg::CTRL_WE_BIT]) |=> !onchip_external_data_ram_we)
    else $error("external-move write reached ram with write enable set");
  a_ram_route: assert property (
    (xm_wr && !ctrl_r[fpeg_pkg::CTRL_WE_BIT] && !stall_r) |=> onchip_external_data_ram_we &&
      onchip_external_data_ram_addr == $past(xm_addr) && onchip_external_data_ram_wdata == $past(xm_data))
    else $error("external-move write missed the ram");
  a_we_hold: assert property (
    (ctrl_r[fpeg_pkg::CTRL_WE_BIT] && !ctrl_wr) |=> ctrl_r[fpeg_pkg::CTRL_WE_BIT])
    else $error("write enable cleared without a software write");
  a_prog_clear: assert property (
    $rose(fprog_r) |-> (fwdata_r & ~old_r) == 8'h00 && fwdata_r == (old_r & data_r))
    else $error("program would set a bit to one");
  a_erase_page: assert property (
    $rose(ferase_r) |-> faddr_r[fpeg_pkg::PAGE_AW-1:0] == 9'h000 &&
      fwdata_r == fpeg_pkg::ERASED_BYTE && $past(ctrl_r[fpeg_pkg::CTRL_EE_BIT]))
    else $error("erase not aligned to page or not ones");
  a_op_length: assert property (
    $fell(fprog_r || ferase_r) |-> $past(plen_r) + 32'h0000_0001 ==
      ($past(fprog_r) ? WRITE_CYC : ERASE_CYC))
    else $error("op strobe length differs from its timer");
  a_stall_cover: assert property (
    (op_r != fpeg_pkg::OP_IDLE) |-> stall_r)
    else $error("core not stalled during flash op");
  a_reserved_err: assert property (
    (to_flash && is_reserved(xm_addr)) |=> flash_err_rst && !fprog_r && !ferase_r)
    else $error("reserved access neither refused nor reset");
  a_ctrl_neutral: assert property (
    (ctrl_wr && !to_flash) |=> key_r == $past(key_r))
    else $error("control write moved the unlock state");

  c_byte_prog:  cover property ($fell(fprog_r));
  c_page_erase: cover property ($fell(ferase_r));
  c_lockout:    cover property ($rose(key_r == fpeg_pkg::KS_LOCKOUT));
  c_ram_write:  cover property (onchip_external_data_ram_we);
endmodule : fpeg_guard
`default_nettype wire

// ---- verilog/fpeg_pkg.sv ----
// constants, register map and state types for the flash program/erase guard
// assumes a 250 MHz pclk and a 13-bit flash byte address space
package fpeg_pkg;
  // unlock codes, taken in this order
  localparam logic [7:0]  KEY_FIRST      = 8'ha5;
  localparam logic [7:0]  KEY_SECOND     = 8'hf1;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  // apb register offsets
  localparam int          APB_AW         = 12;
  localparam logic [11:0] CTRL_OFF       = 12'h000;
  localparam logic [11:0] KEY_OFF        = 12'h004;
  localparam logic [11:0] STAT_OFF       = 12'h008;
  // control fields
  localparam int          CTRL_WE_BIT    = 0;
  localparam int          CTRL_EE_BIT    = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  // status fields
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_LOCK_BIT  = 1;
  localparam int          STAT_OPEN_BIT  = 2;
  localparam int          STAT_FIRST_BIT = 3;
  // flash geometry
  localparam int          FLASH_AW       = 13;
  localparam int          XM_AW          = 16;
  localparam int          PAGE_AW        = 9;
  localparam logic [12:0] RESERVED_BASE  = 13'h1e00;
  // operation timing
  localparam int          CLK_MHZ        = 250;
  localparam int          ERASE_TIME_US  = 20000;
  localparam int          WRITE_TIME_US  = 70;
  localparam int          ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
  localparam int          WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
  localparam int          CNT_W          = 32;

  typedef enum logic [1:0] {
    KS_LOCKED  = 2'b00,
    KS_FIRST   = 2'b01,
    KS_OPEN    = 2'b10,
    KS_LOCKOUT = 2'b11
  } fpeg_key_t;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_PROG  = 2'b10,
    OP_ERASE = 2'b11
  } fpeg_op_t;
endpackage : fpeg_pkg

// ---- testbench/fpeg_flash_model.sv ----
// flash macro model: combinational read, program and erase applied as the strobe rises
// assumes the guard's flash port runs on the same pclk
`timescale 1ns/100ps
`default_nettype none
module fpeg_flash_model (
  // clock
  input  wire logic        pclk,
  // flash port
  input  wire logic [12:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  input  wire logic        flash_prog,
  input  wire logic        flash_erase,
  output var  logic [7:0]  flash_rdata
);
  logic [7:0] mem [8192];
  logic       prog_q;
  logic       erase_q;
  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'h5a;
    prog_q = 1'b0;
    erase_q = 1'b0;
  end
  assign flash_rdata = mem[flash_addr];
  // plain overwrite: the guard itself must keep bits from rising
  always @(posedge pclk)
  begin
    if (flash_prog && !prog_q)
      mem[flash_addr] <= flash_wdata;
    if (flash_erase && !erase_q)
      for (int i = 0; i < 512; i++)
        mem[{flash_addr[12:9], i[8:0]}] <= 8'hff;
    prog_q <= flash_prog;
    erase_q <= flash_erase;
  end
endmodule : fpeg_flash_model
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the flash program/erase guard
// assumes fpeg_pkg, fpeg_guard and fpeg_flash_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int ECYC = 20;
  localparam int WCYC = 5;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        xm_wr, cpu_stall, flash_err_rst, onchip_external_data_ram_we, flash_prog, flash_erase;
  logic [15:0] xm_addr, onchip_external_data_ram_addr;
  logic [7:0]  xm_data, onchip_external_data_ram_wdata, flash_rdata, flash_wdata, d1, d2;
  logic [12:0] flash_addr, fa;
  logic [15:0] xa;
  logic        err_seen;
  int          bad_count, comparisons, cycles, s, p;
  logic [15:0] bad_keys [3] = '{16'hf1a5, 16'ha500, 16'ha5a5};

  fpeg_guard #(.ERASE_CYC(ECYC), .WRITE_CYC(WCYC)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xm_wr(xm_wr), .xm_addr(xm_addr), .xm_data(xm_data), .cpu_stall(cpu_stall),
    .flash_err_rst(flash_err_rst), .onchip_external_data_ram_we(onchip_external_data_ram_we), .onchip_external_data_ram_addr(onchip_external_data_ram_addr),
    .onchip_external_data_ram_wdata(onchip_external_data_ram_wdata), .flash_rdata(flash_rdata), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_prog(flash_prog), .flash_erase(flash_erase));
  fpeg_flash_model m_u (
    .pclk(pclk), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_rdata(flash_rdata));

  always #2 pclk = ~pclk;

  // erase clears the whole page that holds the address
  function automatic logic [12:0] page_of(input logic [12:0] a);
    page_of = {a[12:9], 9'h000};
  endfunction : page_of

  // a program can only clear bits of what the cell already holds
  function automatic logic [7:0] prog_exp(input logic [7:0] old, input logic [7:0] d);
    prog_exp = old & d;
  endfunction : prog_exp

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
  endtask : apb

  task automatic key(input logic [7:0] d);
    apb(1'b1, fpeg_pkg::KEY_OFF, {24'h0, d});
  endtask : key

  task automatic xm(input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    xm_wr <= 1'b1;
    xm_addr <= a;
    xm_data <= d;
    @(posedge pclk);
    xm_wr <= 1'b0;
    #1;
  endtask : xm

  // counts stall cycles and strobe cycles of one flash operation
  task automatic op_len;
    s = 0;
    p = 0;
    while (cpu_stall === 1'b1 && s < 5000)
    begin
      if (flash_prog === 1'b1 || flash_erase === 1'b1)
        p++;
      s++;
      @(posedge pclk);
      #1;
    end
  endtask : op_len

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; xm_wr = 1'b0; xm_addr = 16'h0; xm_data = 8'h00;
    bad_count = 0; comparisons = 0; cycles = 0;
    s = $urandom(72031);
    do_reset();
    apb(1'b0, fpeg_pkg::CTRL_OFF, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b1, 12'h00c, 32'h0000_00a5);
    chk("unmapped err", {31'h0, err_seen}, 32'h1);
    // ram path with write enable clear
    d1 = 8'($urandom);
    xa = 16'($urandom);
    xm(xa, d1);
    chk("onchip_external_data_ram_we", {31'h0, onchip_external_data_ram_we}, 32'h1);
    chk("onchip_external_data_ram_addr", {16'h0, onchip_external_data_ram_addr}, {16'h0, xa});
    chk("onchip_external_data_ram_wdata", {24'h0, onchip_external_data_ram_wdata}, {24'h0, d1});
    chk("onchip_external_data_ram stall", {31'h0, cpu_stall}, 32'h0);
    // page erase, data byte ignored
    fa = {4'($urandom_range(14)), 9'($urandom)};
    apb(1'b1, fpeg_pkg::CTRL_OFF, 32'h3);
    key(8'ha5);
    key(8'hf1);
    xm({3'h0, fa}, 8'($urandom));
    chk("erase start", {31'h0, flash_erase}, 32'h1);
    chk("erase page", {19'h0, flash_addr}, {19'h0, page_of(fa)});
    chk("erase data", {24'h0, flash_wdata}, 32'hff);
    op_len();
    chk("erase stall", s, ECYC);
    chk("erase len", p, ECYC);
    chk("erased byte", {24'h0, m_u.mem[fa]}, 32'hff);
    apb(1'b0, fpeg_pkg::STAT_OFF, 32'h0);
    chk("relocked", rd[2:0], 32'h0);
    apb(1'b0, fpeg_pkg::CTRL_OFF, 32'h0);
    chk("ctrl kept", rd, 32'h3);
    // two programs of one byte: bits only fall
    apb(1'b1, fpeg_pkg::CTRL_OFF, 32'h1);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    for (int i = 0; i < 2; i++)
    begin
      key(8'ha5);
      key(8'hf1);
      xm({3'h0, fa}, (i == 0) ? d1 : d2);
      op_len();
      chk("prog stall", s, WCYC + 1);
      chk("prog len", p, WCYC);
    end
    chk("prog byte", {24'h0, m_u.mem[fa]}, {24'h0, prog_exp(prog_exp(8'hff, d1), d2)});
    // long gap, a control write and a status read between codes
    key(8'ha5);
    repeat (200) @(posedge pclk);
    apb(1'b1, fpeg_pkg::CTRL_OFF, 32'h1);
    apb(1'b0, fpeg_pkg::STAT_OFF, 32'h0);
    chk("first held", {28'h0, rd[3:0]}, 32'h8);
    key(8'hf1);
    apb(1'b0, fpeg_pkg::STAT_OFF, 32'h0);
    chk("open", {31'h0, rd[2]}, 32'h1);
    // reserved region access
    fa = {4'hf, 9'($urandom)};
    xm({3'h0, fa}, 8'h00);
    chk("err reset", {31'h0, flash_err_rst}, 32'h1);
    chk("rsv stall", {31'h0, cpu_stall}, 32'h0);
    chk("rsv byte", {24'h0, m_u.mem[fa]}, 32'h5a);
    // consume unlock, then an unkeyed attempt locks out
    fa = {4'($urandom_range(14)), 9'($urandom)};
    xm({3'h0, fa}, 8'h00);
    op_len();
    xm({3'h0, fa}, 8'h00);
    chk("no op", {31'h0, cpu_stall}, 32'h0);
    apb(1'b0, fpeg_pkg::STAT_OFF, 32'h0);
    chk("lockout", {31'h0, rd[1]}, 32'h1);
    key(8'ha5);
    key(8'hf1);
    xm({3'h0, fa}, 8'h00);
    chk("locked op", {31'h0, cpu_stall}, 32'h0);
    // software clears write enable: external moves reach the ram again
    apb(1'b1, fpeg_pkg::CTRL_OFF, 32'h0);
    xa = 16'($urandom);
    xm(xa, d2);
    chk("ram again", {31'h0, onchip_external_data_ram_we}, 32'h1);
    chk("ram again addr", {16'h0, onchip_external_data_ram_addr}, {16'h0, xa});
    // wrong order or value, each after a fresh reset
    for (int i = 0; i < 3; i++)
    begin
      do_reset();
      apb(1'b0, fpeg_pkg::STAT_OFF, 32'h0);
      chk("stat reset", rd, 32'h0);
      key(bad_keys[i][15:8]);
      key(bad_keys[i][7:0]);
      apb(1'b0, fpeg_pkg::STAT_OFF, 32'h0);
      chk("bad key", {31'h0, rd[1]}, 32'h1);
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire
